// file: design/cpm_pkg.sv
// Purpose: Shared constants and types for the charge pump ratio control block.
// Assumes: 20 MHz system clock, 32-bit classic Wishbone register access.
// Notes:   Register offsets are byte addresses of aligned words.
package cpm_pkg;

   // Clock and debounce times, each in its own unit
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned DEB_LONG_MS   = 32;
   localparam int unsigned DEB_SHORT_US  = 200;
   localparam int unsigned DEB_LONG_CYC  = DEB_LONG_MS * (CLK_HZ / 1000);
   localparam int unsigned DEB_SHORT_CYC = DEB_SHORT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned CNT_W         = 20;

   // Register map
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_SRC_EN = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;

   // Control register fields
   localparam int unsigned BIT_AUTO_EN   = 6;
   localparam int unsigned BIT_DEB_SEL   = 5;
   localparam int unsigned BIT_MANUAL    = 4;
   localparam int unsigned BIT_RATIO_SEL = 2;

   // Status register fields
   localparam int unsigned BIT_ST_RUN   = 4;
   localparam int unsigned BIT_ST_RATIO = 5;
   localparam int unsigned LSB_ST_STATE = 6;

   // Values after reset
   localparam logic       RST_AUTO_EN   = 1'b1;
   localparam logic       RST_DEB_SEL   = 1'b0;
   localparam logic       RST_MANUAL    = 1'b0;
   localparam logic       RST_RATIO_SEL = 1'b0;
   localparam logic [3:0] RST_SRC_EN    = 4'h0;

   // Automatic ratio selection states
   typedef enum logic [1:0] {
      CPM_IDLE = 2'b00,
      CPM_LOW  = 2'b01,
      CPM_HIGH = 2'b10
   } cpm_state_type;

endpackage

// file: design/cpm_switch_ctrl.sv
// Purpose: Picks the charge pump ratio (1:1 bypass or 1:2 boost), in automatic or manual policy.
// Assumes: Dropout flags arrive asynchronously from comparators; pattern cycle end comes from same-clock logic.
// Notes:   Automatic selection only climbs; it restarts only when every current source is off.
//
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// - Automatic mode starts the pump at 1:1 and climbs to 1:2 itself.
// - Dropout on an enabled source selects 1:2 after the selected debounce time.
// - Only enabled current sources are watched for dropout.
// - Automatic selection never steps from 1:2 back down to 1:1 while any source stays on.
// - Selection returns to its start only when all sources are off together.
// - After sources re-enable, selection runs again from the start.
// - During a pattern, all sources switch off at each cycle end.
// - Manual mode runs at the programmed ratio, never switching on its own.
// - Manual switch select: 0 automatic policy, 1 manual policy.
// - Ratio select write sets manual ratio; read returns the ratio in use.
// - Auto enable starts pump on dropout of an enabled source; stops when all off.
module cpm_switch_ctrl
   import cpm_pkg::*;
#(
   parameter int unsigned DEB_LONG = DEB_LONG_CYC
) (
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output var  logic [31:0] wb_dat_o,
   output var  logic        wb_ack_o,
   input  wire logic [3:0]  source_dropout,
   input  wire logic        pattern_running,
   input  wire logic        pattern_cycle_end,
   output var  logic [3:0]  current_source_enable,
   output var  logic        pump_run,
   output var  logic        pump_ratio
);

   // Every bit of state lives in one packed record, so the reset value and the
   // next-state copy can never drift apart when a field is added
   typedef struct packed {
      // Bus answer: acknowledge pulse and the read word that rides with it
      logic              ack;
      logic [31:0]       rdata;

      // Software settings, written over the register bus
      logic              auto_en;
      logic              deb_short;
      logic              manual;
      logic              ratio_sel;
      logic [3:0]        src_en;

      // Dropout flags on their way into this clock domain
      logic [3:0]        sync1;
      logic [3:0]        sync2;
      logic [3:0]        sync3;
      logic [3:0]        drop;

      // Automatic selector and its debounce counter
      cpm_state_type     state;
      logic [CNT_W-1:0]  cnt;

      // Pattern gap and the registered outputs
      logic              cycle_off;
      logic              run;
      logic              ratio;
      logic [3:0]        src_out;
   } cpm_regs_type;

   // Power-up contents: bus idle, settings at their defaults, pump off at 1:1
   localparam cpm_regs_type RST_REGS = '{
      // Bus side
      ack:       1'b0,
      rdata:     32'h0000_0000,

      // Settings
      auto_en:   RST_AUTO_EN,
      deb_short: RST_DEB_SEL,
      manual:    RST_MANUAL,
      ratio_sel: RST_RATIO_SEL,
      src_en:    RST_SRC_EN,

      // Synchroniser starts at the no-dropout level, so no false dropout follows reset
      sync1:     4'h0,
      sync2:     4'h0,
      sync3:     4'h0,
      drop:      4'h0,

      // Selector waits for the first enabled source
      state:     CPM_IDLE,
      cnt:       '0,

      // Outputs
      cycle_off: 1'b0,
      run:       1'b0,
      ratio:     1'b0,
      src_out:   4'h0
   };

   cpm_regs_type r;
   cpm_regs_type next_r;

   // Register address match, shared by the read and write paths
   function automatic logic cpm_hit(input logic [7:0] adr, input logic [7:0] ofs);
      cpm_hit = (adr == ofs);
   endfunction

   // Packs the control word for a read; the ratio bit shows the ratio in use,
   // not the manual request, so software can see what the pump really does
   function automatic logic [31:0] cpm_ctrl_word(input logic auto_en,
                                                  input logic deb_short,
                                                  input logic manual,
                                                  input logic ratio);
      logic [31:0] w;
      w                = 32'h0000_0000;
      w[BIT_AUTO_EN]   = auto_en;
      w[BIT_DEB_SEL]   = deb_short;
      w[BIT_MANUAL]    = manual;
      w[BIT_RATIO_SEL] = ratio;
      cpm_ctrl_word    = w;
   endfunction

   // Packs the status word: filtered dropout, run, ratio and selector state
   function automatic logic [31:0] cpm_status_word(input logic [3:0]    drop,
                                                   input logic          run,
                                                   input logic          ratio,
                                                   input cpm_state_type state);
      logic [31:0] w;
      w                              = 32'h0000_0000;
      w[3:0]                         = drop;
      w[BIT_ST_RUN]                  = run;
      w[BIT_ST_RATIO]                = ratio;
      w[LSB_ST_STATE+1:LSB_ST_STATE] = state;
      cpm_status_word                = w;
   endfunction

   // Decoded bus request; all fields sit in byte lane 0, so only sel[0] gates a write
   logic             bus_req;      // Request not yet answered
   logic             bus_wr;       // Write that reaches the field lane
   logic             bus_rd;       // Read of any address
   logic             sel_ctrl;     // Address hits the control word
   logic             sel_src;      // Address hits the source enables
   logic             sel_stat;     // Address hits the status word

   // Selector inputs, derived from registered state only
   logic [3:0]       live_en;
   logic             any_on;
   logic             any_drop;
   logic [CNT_W-1:0] deb_last;
   logic             deb_done;     // Counter has reached the selected debounce end
   logic [3:0]       drop_filt;    // Dropout after the stage agreement test

   // Per-source dropout filter: a level is taken only when stages two and three
   // agree, so a one-cycle glitch never reaches the debounce counter
   for (genvar g = 0; g < 4; g++) begin : g_drop_filt
      assign drop_filt[g] = (r.sync2[g] == r.sync3[g]) ? r.sync3[g] : r.drop[g];
   end

   // Bus request and the sources that are really on this cycle
   always_comb begin
      bus_req  = wb_cyc_i & wb_stb_i & ~r.ack;
      bus_wr   = bus_req & wb_we_i & wb_sel_i[0];
      bus_rd   = bus_req & ~wb_we_i;
      sel_ctrl = cpm_hit(wb_adr_i, OFS_CTRL);
      sel_src  = cpm_hit(wb_adr_i, OFS_SRC_EN);
      sel_stat = cpm_hit(wb_adr_i, OFS_STATUS);
      live_en  = r.src_en & {4{~r.cycle_off}};
      any_on   = |live_en;
      any_drop = |(r.drop & live_en);
      deb_last = r.deb_short ? CNT_W'(DEB_SHORT_CYC - 1) : CNT_W'(DEB_LONG - 1);
      deb_done = (r.cnt >= deb_last);
   end

   always_comb begin
      next_r = r;

      // Dropout synchroniser; a change counts once stages two and three agree
      next_r.sync1 = source_dropout;
      next_r.sync2 = r.sync1;
      next_r.sync3 = r.sync2;
      next_r.drop  = drop_filt;

      // Pattern cycle end forces every source off for one cycle
      next_r.cycle_off = pattern_running & pattern_cycle_end;

      // Wishbone slave: one wait state, unmapped reads give zero, unmapped writes dropped
      next_r.ack   = bus_req;
      next_r.rdata = 32'h0000_0000;
      // A write lands at the taking edge, the same edge that raises the acknowledge
      if (bus_wr) begin
         if (sel_ctrl) begin
            next_r.auto_en   = wb_dat_i[BIT_AUTO_EN];
            next_r.deb_short = wb_dat_i[BIT_DEB_SEL];
            next_r.manual    = wb_dat_i[BIT_MANUAL];
            next_r.ratio_sel = wb_dat_i[BIT_RATIO_SEL];
         end else if (sel_src) begin
            // Enables should be set before the pump starts, so the right sources are watched
            next_r.src_en = wb_dat_i[3:0];
         end
      end
      // Read data is registered and stands only in the acknowledge cycle
      if (bus_rd) begin
         if (sel_ctrl) begin
            next_r.rdata = cpm_ctrl_word(r.auto_en, r.deb_short, r.manual, r.ratio);
         end else if (sel_src) begin
            next_r.rdata = {28'h000_0000, r.src_en};
         end else if (sel_stat) begin
            next_r.rdata = cpm_status_word(r.drop, r.run, r.ratio, r.state);
         end
      end

      // Automatic ratio selection; the debounce counter only runs while dropout holds
      // The counter clears whenever it is not counting, so any break in dropout
      // restarts the whole debounce; a marginal supply cannot creep up in pieces
      next_r.cnt = '0;
      case (r.state)
         // Waiting for the first enabled source; the pump sits at 1:1
         CPM_IDLE: begin
            if (any_on) begin
               next_r.state = CPM_LOW;
            end
         end
         // Running at 1:1 and watching the live sources for dropout
         CPM_LOW: begin
            if (!any_on) begin
               next_r.state = CPM_IDLE;
            end else if (any_drop) begin
               if (deb_done) begin
                  next_r.state = CPM_HIGH;
               end else begin
                  next_r.cnt = r.cnt + CNT_W'(1);
               end
            end
         end
         // Running at 1:2; a rising battery does not bring the ratio back down
         CPM_HIGH: begin
            // No path back to 1:1 while any source stays on
            if (!any_on) begin
               next_r.state = CPM_IDLE;
            end
         end
         default: begin
            next_r.state = CPM_IDLE;
         end
      endcase

      // Ratio in use: manual setting, or the climb of the automatic selector
      if (r.manual) begin
         next_r.ratio = r.ratio_sel;
      end else begin
         next_r.ratio = (r.state == CPM_HIGH);
      end

      // Pump run: start on dropout of a live source, stop once all are off;
      // manual ratio policy leaves this alone, the pump still needs a cause to start
      if (!r.auto_en || !any_on) begin
         next_r.run = 1'b0;
      end else if (any_drop) begin
         next_r.run = 1'b1;
      end

      next_r.src_out = live_en;
   end

   // All block state in one register bank; reset loads constants only,
   // so the asynchronous branch never depends on live inputs
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         r <= RST_REGS;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from flip-flops; no logic sits between the
   // register bank and the pins, so downstream timing sees clean edges
   always_comb begin
      wb_ack_o              = r.ack;
      wb_dat_o              = r.rdata;
      pump_run              = r.run;
      pump_ratio            = r.ratio;
      current_source_enable = r.src_out;
   end

endmodule

`default_nettype wire

// file: dv/cpm_switch_ctrl_checker.sv
// Purpose: Port-level assertions for the pump ratio control.
// Assumes: One clock, rstn asynchronous and active low.
// Notes:   Debounce lengths are not visible here; only causes and bounds are.
`timescale 1ns/10ps
`default_nettype none
module cpm_switch_ctrl_checker (
   input wire logic        clk_sys,
   input wire logic        rstn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic [3:0]  source_dropout,
   input wire logic        pattern_running,
   input wire logic        pattern_cycle_end,
   input wire logic [3:0]  current_source_enable,
   input wire logic        pump_run,
   input wire logic        pump_ratio
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   // A request still waiting for its answer
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   // Every request is acknowledged on the next clock
   a_ack_next: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
   a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("read data outside ack");
   a_cycle_end_off: assert property (pattern_running && pattern_cycle_end |-> ##2 current_source_enable == 4'h0) else $error("sources on after cycle end");
   a_run_all_off: assert property ((current_source_enable == 4'h0) [*3] |-> !pump_run) else $error("pump runs with sources off");
   a_rise_has_drop: assert property ($rose(pump_ratio) |-> $past(wb_ack_o && wb_we_i) || $past(source_dropout != 4'h0, 6)) else $error("ratio up without dropout");
   a_ratio_no_down: assert property (pump_ratio && current_source_enable != 4'h0 && !wb_ack_o && !pattern_cycle_end |=> pump_ratio) else $error("ratio stepped down");
endmodule
`default_nettype wire

// file: dv/cpm_switch_ctrl_tb_top.sv
// Purpose: Self-checking bench for the pump ratio control.
// Assumes: Long debounce cut to DL cycles; short one stays at its real count.
// Notes:   Expected ratio and run level come from the rules, not from the design.
`timescale 1ns/10ps
`default_nettype none
module cpm_switch_ctrl_tb_top import cpm_pkg::*;;
   localparam int DL = 50;
   logic        clk_sys, rstn, cyc, stb, we, ack, pr, pe, run, ratio;
   logic [7:0]  adr;
   logic [31:0] wd, rdat, q;
   logic [3:0]  sel, drop, en, en_o;
   int          num_errors, tests_run, seed;
   cpm_switch_ctrl #(.DEB_LONG(DL)) i_cpm_switch_ctrl (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat),
      .wb_ack_o(ack), .source_dropout(drop), .pattern_running(pr), .pattern_cycle_end(pe),
      .current_source_enable(en_o), .pump_run(run), .pump_ratio(ratio));
   // Free-running system clock
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   // One classic cycle; waits for ack, never a fixed count
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_sys);
         n++;
      end while (ack !== 1'b1 && n < 16);
      if (n >= 16) begin
         num_errors++;
         report_and_stop();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic hold(input logic [3:0] d, input int c);
      @(posedge clk_sys);
      drop <= d;
      repeat (c) @(posedge clk_sys);
   endtask
   // Ratio and run compared together, away from the clock edge
   task automatic cmp(input string n, input logic r, input logic u);
      @(negedge clk_sys);
      chk(n, {30'h0, ratio, run}, {30'h0, r, u});
      $display("test %s done", n);
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Watchdog sized well above the short debounce run
   initial begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end
   initial begin
      seed = 32'hd006;
      {cyc, stb, we, pr, pe, rstn} = '0;
      {adr, wd, sel, drop} = '0;
      repeat (3) @(posedge clk_sys);
      rstn <= 1'b1;
      bus(0, OFS_CTRL, 0);
      chk("ctrl reset", q, 32'h0000_0040);
      bus(0, 8'h0c, 0);
      chk("unmapped", q, 0);
      bus(1, OFS_SRC_EN, 1);
      hold(4'h4, 80);
      cmp("disabled source", 0, 0);
      hold(4'h1, 40);
      hold(4'h0, 10);
      hold(4'h1, 40);
      cmp("debounce break", 0, 1);
      hold(4'h1, 40);
      cmp("long debounce", 1, 1);
      bus(0, OFS_CTRL, 0);
      chk("ratio read", q[BIT_RATIO_SEL], 1);
      hold(4'h0, 30);
      cmp("no step down", 1, 1);
      bus(1, OFS_SRC_EN, 0);
      hold(4'h0, 5);
      cmp("all off", 0, 0);
      en = 4'($random(seed)) | 4'h1;
      bus(1, OFS_SRC_EN, {28'h0, en});
      hold(4'h0, 5);
      cmp("restart", 0, 0);
      hold(en, 80);
      cmp("random sources", 1, 1);
      hold(4'h0, 5);
      cmp("held before cycle end", 1, 1);
      @(posedge clk_sys);
      pr <= 1'b1;
      pe <= 1'b1;
      @(posedge clk_sys);
      pe <= 1'b0;
      @(posedge clk_sys);
      @(negedge clk_sys);
      chk("cycle off", {28'h0, en_o}, 0);
      hold(4'h0, 5);
      cmp("pattern reset", 0, 0);
      pr <= 1'b0;
      bus(1, OFS_CTRL, 32'h0000_0054);
      hold(4'h0, 3);
      cmp("manual high", 1, 0);
      bus(1, OFS_CTRL, 32'h0000_0050);
      hold(en, 80);
      cmp("manual low", 0, 1);
      bus(1, OFS_SRC_EN, 0);
      bus(1, OFS_CTRL, 32'h0000_0060);
      bus(1, OFS_SRC_EN, {28'h0, en});
      hold(en, DEB_SHORT_CYC - 100);
      cmp("short early", 0, 1);
      hold(en, 200);
      cmp("short up", 1, 1);
      bus(1, OFS_CTRL, 0);
      hold(en, 5);
      chk("auto off", {31'h0, run}, 0);
      report_and_stop();
   end
endmodule
bind cpm_switch_ctrl cpm_switch_ctrl_checker i_chk (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .source_dropout(source_dropout), .pattern_running(pattern_running),
   .pattern_cycle_end(pattern_cycle_end), .current_source_enable(current_source_enable), .pump_run(pump_run),
   .pump_ratio(pump_ratio));
`default_nettype wire
